// *** core/crsel_pulse_count.sv ***
/*
 * Edge counter with a sticky done flag, cleared by a level.
 * Assumes tick is a one-cycle pulse on the block's clock.
 */
`timescale 1ns/1ps
`default_nettype none

module crsel_pulse_count #(
	parameter int WIDTH = 16
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clear,
	input wire logic tick,
	input wire logic [WIDTH-1:0] target,
	output logic done
);
	logic [WIDTH-1:0] cnt_q, cnt_d;
	logic done_q, done_d;

	always_comb begin
		cnt_d = cnt_q;
		done_d = done_q;
		if (clear) begin
			cnt_d = '0;
			done_d = 1'h0;
		end else if (tick && !done_q) begin
			cnt_d = cnt_q + 1'h1;
			done_d = (cnt_d == target);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cnt_q <= '0;
			done_q <= 1'h0;
		end else begin
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;

endmodule : crsel_pulse_count

`default_nettype wire

// *** core/crsel_sync.sv ***
/*
 * Three-stage synchroniser for one pin level; the output moves only
 * when the second and third stages agree.
 * Assumes an asynchronous input and the block's single clock.
 */
`timescale 1ns/1ps
`default_nettype none

module crsel_sync (
	input wire logic clock,
	input wire logic reset,
	input wire logic pin,
	output logic level
);
	logic s1_q, s1_d;
	logic s2_q, s2_d;
	logic s3_q, s3_d;
	logic out_q, out_d;

	always_comb begin
		s1_d = pin;
		s2_d = s1_q;
		s3_d = s2_q;
		// Filters a one-sample spike
		out_d = (s2_q == s3_q) ? s2_q : out_q;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s1_q <= 1'h0;
			s2_q <= 1'h0;
			s3_q <= 1'h0;
			out_q <= 1'h0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			out_q <= out_d;
		end
	end

	assign level = out_q;

endmodule : crsel_sync

`default_nettype wire

// *** core/crsel_top.sv ***
/*
 * CPU clock source selector: crystal warm-up mask, external clock
 * detection, glitch-free CPU clock choice and prescaler routing.
 * Assumes control writes and sleep come from logic on clock; the RC,
 * crystal and pin levels are asynchronous and sampled at 20 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
`include "crsel_map.svh"

module crsel_top (
	input wire logic clock,
	input wire logic reset,
	input wire logic sleep,
	input wire logic ctrl_we,
	input wire crsel_pkg::crsel_ctrl_s ctrl_wdata,
	input wire logic pre_clear_req,
	input wire logic rc_clock_in,
	input wire logic xtal_clock_in,
	input wire logic oscin_pin,
	output crsel_pkg::crsel_stat_s status,
	output logic rc_osc_run,
	output logic xtal_osc_run,
	output logic cpu_clock,
	output crsel_pkg::crsel_src_e cpu_src,
	output logic high_pre_clock,
	output logic low_pre_clock,
	output logic low_pre_clear
);

	// ****************************************************************
	// Pin sampling
	// ****************************************************************
	logic [`CRSEL_NUM_PINS-1:0] pin_raw;
	logic [`CRSEL_NUM_PINS-1:0] pin_lvl;
	logic [`CRSEL_NUM_PINS-1:0] pin_prev_q, pin_prev_d;
	logic [`CRSEL_NUM_PINS-1:0] pin_rise;
	logic rc_lvl;
	logic xtal_lvl;
	logic ext_lvl;
	logic xtal_rise;
	logic ext_rise;

	assign pin_raw = {oscin_pin, xtal_clock_in, rc_clock_in};

	genvar gi;
	generate
		for (gi = 0; gi < `CRSEL_NUM_PINS; gi++) begin : g_sync
			crsel_sync u_sync (
				.clock(clock),
				.reset(reset),
				.pin(pin_raw[gi]),
				.level(pin_lvl[gi])
			);
		end
	endgenerate

	always_comb begin
		pin_prev_d = pin_lvl;
		pin_rise = pin_lvl & ~pin_prev_q;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pin_prev_q <= '0;
		end else begin
			pin_prev_q <= pin_prev_d;
		end
	end

	assign rc_lvl = pin_lvl[0];
	assign xtal_lvl = pin_lvl[1];
	assign ext_lvl = pin_lvl[2];
	assign xtal_rise = pin_rise[1];
	assign ext_rise = pin_rise[2];

	// ****************************************************************
	// Control bits
	// ****************************************************************
	logic cpu_sel_q, cpu_sel_d;
	logic ext_allow_q, ext_allow_d;
	logic xtal_on_q, xtal_on_d;
	logic rc_on_q, rc_on_d;
	logic sleep_q, sleep_d;
	logic ext_seen_q, ext_seen_d;
	logic warming_q, warming_d;
	logic pre_clear_q, pre_clear_d;
	logic warm_done;
	logic ext_done;
	logic ext_block;

	always_comb begin
		sleep_d = sleep;
		cpu_sel_d = cpu_sel_q;
		ext_allow_d = ext_allow_q;
		xtal_on_d = xtal_on_q;
		rc_on_d = rc_on_q;
		ext_block = ext_seen_q | ext_allow_q;
		if (ctrl_we) begin
			cpu_sel_d = ctrl_wdata.cpu_sel;
			ext_allow_d = ctrl_wdata.ext_clock_allow;
			rc_on_d = ctrl_wdata.rc_osc_on;
			ext_block = ext_block | ctrl_wdata.ext_clock_allow;
			xtal_on_d = ctrl_wdata.crystal_osc_on & ~ext_block;
		end
		if (sleep_q && !sleep) begin
			rc_on_d = 1'h1;
			cpu_sel_d = 1'h0;
		end
		if (sleep) begin
			xtal_on_d = 1'h0;
			rc_on_d = 1'h0;
			cpu_sel_d = 1'h0;
		end
	end

	// ****************************************************************
	// Warm-up and detection counters
	// ****************************************************************
	// counts synchronised source edges
	crsel_pulse_count #(
		.WIDTH(`CRSEL_WARM_W)
	) u_warm (
		.clock(clock),
		.reset(reset),
		.clear(~xtal_on_q),
		.tick(xtal_rise),
		.target(`CRSEL_WARM_EDGES),
		.done(warm_done)
	);

	crsel_pulse_count #(
		.WIDTH(`CRSEL_EXT_W)
	) u_ext (
		.clock(clock),
		.reset(reset),
		.clear(~ext_allow_q),
		.tick(ext_rise),
		.target(`CRSEL_EXT_PULSES),
		.done(ext_done)
	);

	always_comb begin
		// Detection holds until reset
		ext_seen_d = ext_seen_q | ext_done;
		warming_d = ~(xtal_on_q & warm_done);
		if (sleep || !xtal_on_d) begin
			warming_d = 1'h1;
		end
		pre_clear_d = (xtal_on_d & ~xtal_on_q) | pre_clear_req;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sleep_q <= 1'h0;
			cpu_sel_q <= `CRSEL_RST_CPU_SEL;
			ext_allow_q <= `CRSEL_RST_EXT_ALLOW;
			xtal_on_q <= `CRSEL_RST_XTAL_ON;
			rc_on_q <= `CRSEL_RST_RC_ON;
			ext_seen_q <= `CRSEL_RST_EXT_SEEN;
			warming_q <= `CRSEL_RST_WARMING;
			pre_clear_q <= 1'h0;
		end else begin
			sleep_q <= sleep_d;
			cpu_sel_q <= cpu_sel_d;
			ext_allow_q <= ext_allow_d;
			xtal_on_q <= xtal_on_d;
			rc_on_q <= rc_on_d;
			ext_seen_q <= ext_seen_d;
			warming_q <= warming_d;
			pre_clear_q <= pre_clear_d;
		end
	end

	// ****************************************************************
	// Source choice
	// ****************************************************************
	logic xtal_usable;
	logic xtal_ok_lvl;
	crsel_pkg::crsel_src_e want_src;

	always_comb begin
		xtal_usable = xtal_on_q & ~ext_allow_q & ~ext_seen_q;
		xtal_ok_lvl = xtal_lvl & xtal_on_q & ~warming_q;
		if (!cpu_sel_q) begin
			want_src = rc_on_q ? crsel_pkg::SRC_RC : crsel_pkg::SRC_OFF;
		end else if (xtal_usable) begin
			want_src = crsel_pkg::SRC_XTAL;
		end else begin
			want_src = crsel_pkg::SRC_EXT;
		end
	end

	function automatic logic src_level(
		input crsel_pkg::crsel_src_e src,
		input logic rc_l,
		input logic xt_l,
		input logic ex_l
	);
		case (src)
			crsel_pkg::SRC_RC: src_level = rc_l;
			crsel_pkg::SRC_XTAL: src_level = xt_l;
			crsel_pkg::SRC_EXT: src_level = ex_l;
			default: src_level = 1'h0;
		endcase
	endfunction : src_level

	// ****************************************************************
	// Glitch-free CPU clock switch
	// ****************************************************************
	// Leaves the old source only while low and joins the new one only
	// while low, so the first new high phase is always whole.
	crsel_pkg::crsel_src_e cur_src_q, cur_src_d;
	crsel_pkg::crsel_sw_e sw_q, sw_d;
	logic cpu_clk_q, cpu_clk_d;
	logic cur_lvl;
	logic want_lvl;

	always_comb begin
		cur_lvl = src_level(cur_src_q, rc_lvl, xtal_ok_lvl, ext_lvl);
		want_lvl = src_level(want_src, rc_lvl, xtal_ok_lvl, ext_lvl);
		cur_src_d = cur_src_q;
		sw_d = sw_q;
		cpu_clk_d = 1'h0;
		case (sw_q)
			crsel_pkg::SW_RUN: begin
				cpu_clk_d = cur_lvl;
				if (want_src != cur_src_q && !cur_lvl) begin
					sw_d = crsel_pkg::SW_PARK;
					cpu_clk_d = 1'h0;
				end
			end
			crsel_pkg::SW_PARK: begin
				cpu_clk_d = 1'h0;
				if (!want_lvl) begin
					cur_src_d = want_src;
					sw_d = crsel_pkg::SW_RUN;
				end
			end
			default: begin
				sw_d = crsel_pkg::SW_PARK;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cur_src_q <= crsel_pkg::SRC_RC;
			sw_q <= crsel_pkg::SW_RUN;
			cpu_clk_q <= 1'h0;
		end else begin
			cur_src_q <= cur_src_d;
			sw_q <= sw_d;
			cpu_clk_q <= cpu_clk_d;
		end
	end

	// ****************************************************************
	// Prescaler routing
	// ****************************************************************
	logic hi_pre_q, hi_pre_d;
	logic lo_pre_q, lo_pre_d;

	always_comb begin
		hi_pre_d = rc_on_q & rc_lvl;
		if (xtal_usable) begin
			lo_pre_d = xtal_ok_lvl;
		end else begin
			lo_pre_d = hi_pre_d;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			hi_pre_q <= 1'h0;
			lo_pre_q <= 1'h0;
		end else begin
			hi_pre_q <= hi_pre_d;
			lo_pre_q <= lo_pre_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_comb begin
		status.cpu_sel = cpu_sel_q;
		status.ext_clock_seen = ext_seen_q;
		status.ext_clock_allow = ext_allow_q;
		status.crystal_warming = warming_q;
		status.crystal_osc_on = xtal_on_q;
		status.rc_osc_on = rc_on_q;
	end

	assign rc_osc_run = rc_on_q;
	assign xtal_osc_run = xtal_on_q;
	assign cpu_clock = cpu_clk_q;
	assign cpu_src = cur_src_q;
	assign high_pre_clock = hi_pre_q;
	assign low_pre_clock = lo_pre_q;
	assign low_pre_clear = pre_clear_q;

endmodule : crsel_top

`default_nettype wire

// *** include/crsel_map.svh ***
/*
 * Constants of the CPU clock source selector: counts, widths and the
 * values that control state takes after reset.
 * Assumes inclusion by bare name from any file that needs a figure.
 */
`ifndef CRSEL_MAP_SVH
`define CRSEL_MAP_SVH

// ****************************************************************
// Counts
// ****************************************************************
// Crystal edges masked while the oscillator warms up
`define CRSEL_WARM_W 16
`define CRSEL_WARM_EDGES 16'h8000
// Pin edges that prove an external clock is present
`define CRSEL_EXT_W 3
`define CRSEL_EXT_PULSES 3'h4

// ****************************************************************
// Reset values of the control and status bits
// ****************************************************************
`define CRSEL_RST_CPU_SEL 1'h0
`define CRSEL_RST_EXT_SEEN 1'h0
`define CRSEL_RST_EXT_ALLOW 1'h0
`define CRSEL_RST_WARMING 1'h1
`define CRSEL_RST_XTAL_ON 1'h0
`define CRSEL_RST_RC_ON 1'h1

// ****************************************************************
// Synchroniser depth and count
// ****************************************************************
`define CRSEL_SYNC_STAGES 3
`define CRSEL_NUM_PINS 3

`endif

// *** include/crsel_pkg.sv ***
/*
 * Types of the CPU clock source selector: sources, switch states and
 * the structs that carry control writes and status.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package crsel_pkg;

	// ****************************************************************
	// Enumerations
	// ****************************************************************
	typedef enum logic [1:0] {
		SRC_OFF,
		SRC_RC,
		SRC_XTAL,
		SRC_EXT
	} crsel_src_e;

	typedef enum logic {
		SW_RUN,
		SW_PARK
	} crsel_sw_e;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic cpu_sel;
		logic ext_clock_allow;
		logic crystal_osc_on;
		logic rc_osc_on;
	} crsel_ctrl_s;

	typedef struct packed {
		logic cpu_sel;
		logic ext_clock_seen;
		logic ext_clock_allow;
		logic crystal_warming;
		logic crystal_osc_on;
		logic rc_osc_on;
	} crsel_stat_s;

endpackage : crsel_pkg

// *** tb/crsel_osc_model.sv ***
/*
 * Crystal and external clock generator at the oscillator pins.
 * Assumes the bench commands hold and the external generator.
 */
`timescale 1ns/1ps
`default_nettype none

module crsel_osc_model (
	input wire logic xtal_run,
	input wire logic xtal_hold,
	input wire logic ext_run,
	output var logic xtal_clock_in,
	output var logic oscin_pin,
	output int xtal_edges,
	output int ext_edges
);
	// ****************************************************************
	// Generators
	// ****************************************************************
	// Fast crystal: 4 system clocks a period keeps the run short
	initial begin
		xtal_clock_in = 1'h0;
		xtal_edges = 0;
		#7;
		forever begin
			#100;
			// Count restarts while the oscillator is off
			if (!xtal_run) begin
				xtal_edges = 0;
			end
			if ((xtal_run && !xtal_hold) || xtal_clock_in) begin
				xtal_clock_in = !xtal_clock_in;
				xtal_edges += int'(xtal_clock_in);
			end
		end
	end
	// Stopped generator rests low; 250 ns phases meet pulse width
	initial begin
		oscin_pin = 1'h0;
		ext_edges = 0;
		forever begin
			#250;
			if (ext_run || oscin_pin) begin
				oscin_pin = !oscin_pin;
				ext_edges += int'(oscin_pin);
			end
		end
	end
endmodule : crsel_osc_model

`default_nettype wire

// *** tb/crsel_top_props.sv ***
/*
 * Port checker for the CPU clock source selector.
 * Assumes binding to crsel_top, one clock, async active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module crsel_top_props (
	input wire logic clock,
	input wire logic reset,
	input wire logic sleep,
	input wire logic ctrl_we,
	input wire crsel_pkg::crsel_ctrl_s ctrl_wdata,
	input wire logic pre_clear_req,
	input wire crsel_pkg::crsel_stat_s status,
	input wire logic xtal_osc_run,
	input wire logic cpu_clock,
	input wire crsel_pkg::crsel_src_e cpu_src,
	input wire logic high_pre_clock,
	input wire logic low_pre_clear
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	logic ext_on;
	assign ext_on = status.ext_clock_allow || status.ext_clock_seen;

	AST_SLEEP_STOP: assert property (
		sleep |=> !status.crystal_osc_on && status.crystal_warming
			&& !xtal_osc_run) else $error("sleep left crystal up");
	AST_XTAL_REFUSE: assert property (
		ctrl_we && (ext_on || ctrl_wdata.ext_clock_allow)
			|=> !status.crystal_osc_on) else $error("crystal set");
	AST_WARM_MASK: assert property (
		$past(status.crystal_warming)
			|-> !(cpu_src == crsel_pkg::SRC_XTAL && cpu_clock))
		else $error("cold crystal on cpu");
	AST_WARM_CLEAR: assert property (
		$fell(status.crystal_warming) |-> status.crystal_osc_on)
		else $error("warming cleared while off");
	AST_EXT_DETECT: assert property (
		!ext_on && !$past(ext_on) |=> !status.ext_clock_seen)
		else $error("ext seen without allow");
	AST_HIGH_PRE: assert property (
		high_pre_clock |-> $past(status.rc_osc_on))
		else $error("high prescaler without rc");
	AST_SEL_RC: assert property (
		!status.cpu_sel && status.rc_osc_on
			|-> ##[0:40] cpu_src == crsel_pkg::SRC_RC)
		else $error("rc not selected");
	AST_SEL_OFF: assert property (
		!status.cpu_sel && !status.rc_osc_on
			|-> ##[0:40] cpu_src == crsel_pkg::SRC_OFF)
		else $error("cpu clock not off");
	AST_SEL_EXT: assert property (
		status.cpu_sel && ext_on
			|-> ##[0:40] cpu_src == crsel_pkg::SRC_EXT)
		else $error("ext not selected");
	AST_SEL_XTAL: assert property (
		status.cpu_sel && status.crystal_osc_on && !ext_on
			|-> ##[0:60] cpu_src == crsel_pkg::SRC_XTAL)
		else $error("crystal not selected");
	AST_SWITCH_LOW: assert property (
		!$stable(cpu_src) |-> !cpu_clock) else $error("switch glitch");
	AST_XTAL_CLEAR: assert property (
		ctrl_we && ctrl_wdata.crystal_osc_on && !status.crystal_osc_on
			&& !sleep && !ext_on && !ctrl_wdata.ext_clock_allow
			|=> low_pre_clear) else $error("no prescaler clear");
	AST_PRE_CLEAR: assert property (
		pre_clear_req |=> low_pre_clear) else $error("clear lost");
endmodule : crsel_top_props

bind crsel_top crsel_top_props i_crsel_top_props (.clock(clock),
	.reset(reset), .sleep(sleep), .ctrl_we(ctrl_we),
	.ctrl_wdata(ctrl_wdata), .pre_clear_req(pre_clear_req),
	.status(status), .xtal_osc_run(xtal_osc_run),
	.cpu_clock(cpu_clock), .cpu_src(cpu_src),
	.high_pre_clock(high_pre_clock), .low_pre_clear(low_pre_clear));

`default_nettype wire

// *** tb/crsel_top_tb.sv ***
/*
 * Self-checking bench of the CPU clock source selector.
 * Assumes crsel_top, the checker bind and the oscillator model.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin \
	error_cnt++; $display("CHECK FAILED at %0t: %s", $time, m); end end

module crsel_top_tb;
	// ****************************************************************
	// Stimulus and checks
	// ****************************************************************
	logic clock = 1'h0, reset = 1'h1, sleep = 1'h0, ctrl_we = 1'h0;
	logic pre_clear_req = 1'h0, rc_clock_in = 1'h0, xtal_clock_in;
	logic oscin_pin, xtal_hold = 1'h0, ext_run = 1'h0;
	logic rc_osc_run, xtal_osc_run, cpu_clock, high_pre_clock;
	logic low_pre_clock, low_pre_clear;
	crsel_pkg::crsel_ctrl_s ctrl_wdata = 4'h0;
	crsel_pkg::crsel_stat_s status;
	crsel_pkg::crsel_src_e cpu_src;
	int xtal_edges, ext_edges, error_cnt = 0, cmp_count = 0, cycles = 0;
	int cpu_r = 0, hi_r = 0, lo_r = 0, cpu_m, hi_m, lo_m;

	crsel_top i_crsel_top (.clock(clock), .reset(reset), .sleep(sleep),
		.ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
		.pre_clear_req(pre_clear_req), .rc_clock_in(rc_clock_in),
		.xtal_clock_in(xtal_clock_in), .oscin_pin(oscin_pin),
		.status(status), .rc_osc_run(rc_osc_run),
		.xtal_osc_run(xtal_osc_run), .cpu_clock(cpu_clock),
		.cpu_src(cpu_src), .high_pre_clock(high_pre_clock),
		.low_pre_clock(low_pre_clock), .low_pre_clear(low_pre_clear));
	crsel_osc_model i_crsel_osc_model (.xtal_run(xtal_osc_run),
		.xtal_hold(xtal_hold), .ext_run(ext_run),
		.xtal_clock_in(xtal_clock_in), .oscin_pin(oscin_pin),
		.xtal_edges(xtal_edges), .ext_edges(ext_edges));

	always #25 clock = !clock;
	// Rise counts give the rates of the clock outputs
	always @(posedge cpu_clock) cpu_r++;
	always @(posedge high_pre_clock) hi_r++;
	always @(posedge low_pre_clock) lo_r++;
	// RC rests low when stopped
	always #175 if (rc_osc_run || rc_clock_in) rc_clock_in = !rc_clock_in;
	// Crystal warm-up alone is about 131k cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 200000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	// Returns at the falling edge after the taking edge
	task automatic wr(input crsel_pkg::crsel_ctrl_s v);
		@(negedge clock);
		ctrl_we = 1'h1;
		ctrl_wdata = v;
		@(negedge clock);
		ctrl_we = 1'h0;
	endtask : wr

	task automatic end_of_test();
		if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		cyc(10);
		reset = 1'h0;
		`CHK(status, 6'h05, "reset status")
		`CHK(cpu_src, crsel_pkg::SRC_RC, "reset source")
		pre_clear_req = 1'h1;
		cyc(1);
		pre_clear_req = 1'h0;
		`CHK(low_pre_clear, 1'h1, "clear request")
		wr(4'h0);
		cyc(40);
		`CHK(cpu_src, crsel_pkg::SRC_OFF, "rc off gives off")
		`CHK(high_pre_clock, 1'h0, "high pre off")
		cpu_m = cpu_r;
		cyc(20);
		`CHK(cpu_r - cpu_m, 0, "cpu clock off")
		wr(4'h1);
		wr(4'h3);
		`CHK(low_pre_clear, 1'h1, "clear on crystal enable")
		`CHK(status, 6'h07, "crystal on, warming")
		`CHK(xtal_osc_run, 1'h1, "crystal running")
		wr(4'hb);
		while (xtal_edges < 32767) cyc(1);
		xtal_hold = 1'h1;
		cyc(40);
		`CHK(status.crystal_warming, 1'h1, "warm after 32767")
		xtal_hold = 1'h0;
		cyc(20);
		`CHK(status.crystal_warming, 1'h0, "warm done")
		cyc(60);
		`CHK(cpu_src, crsel_pkg::SRC_XTAL, "crystal selected")
		cpu_m = cpu_r;
		hi_m = hi_r;
		lo_m = lo_r;
		// 280 cycles hold whole crystal and RC periods
		cyc(280);
		`CHK(cpu_r - cpu_m, 70, "crystal cpu rate")
		`CHK(lo_r - lo_m, 70, "crystal low pre rate")
		`CHK(hi_r - hi_m, 40, "rc high pre rate")
		wr(4'ha);
		cyc(20);
		`CHK(rc_osc_run, 1'h0, "rc stopped")
		`CHK(high_pre_clock, 1'h0, "high pre idle")
		wr(4'hb);
		wr(4'h3);
		// Old source is stopped only after the switch is done
		cyc(40);
		wr(4'h1);
		`CHK(xtal_osc_run, 1'h0, "crystal stopped")
		cyc(40);
		`CHK(cpu_src, crsel_pkg::SRC_RC, "back on rc")
		wr(4'h7);
		`CHK(status.crystal_osc_on, 1'h0, "refused with allow")
		ext_run = 1'h1;
		while (ext_edges < 3) cyc(1);
		ext_run = 1'h0;
		cyc(30);
		`CHK(status.ext_clock_seen, 1'h0, "three pulses")
		ext_run = 1'h1;
		while (ext_edges < 4) cyc(1);
		cyc(15);
		`CHK(status.ext_clock_seen, 1'h1, "four pulses")
		wr(4'h3);
		`CHK(status.crystal_osc_on, 1'h0, "refused when seen")
		wr(4'hd);
		wr(4'hc);
		cyc(40);
		`CHK(cpu_src, crsel_pkg::SRC_EXT, "external selected")
		cpu_m = cpu_r;
		repeat (40) begin
			cyc(1);
			`CHK({high_pre_clock, low_pre_clock}, 2'h0, "ext on pre")
		end
		`CHK(cpu_r - cpu_m, 4, "external cpu rate")
		sleep = 1'h1;
		cyc(45);
		`CHK(rc_osc_run, 1'h0, "sleep stops rc")
		`CHK(status.crystal_warming, 1'h1, "sleep warming")
		sleep = 1'h0;
		cyc(2);
		`CHK({status.cpu_sel, rc_osc_run}, 2'h1, "wake on rc")
		cyc(40);
		`CHK(cpu_src, crsel_pkg::SRC_RC, "wake source")
		cpu_m = cpu_r;
		cyc(70);
		`CHK(cpu_r - cpu_m, 10, "rc cpu rate")
		ext_run = 1'h0;
		end_of_test();
	end
endmodule : crsel_top_tb

`default_nettype wire
